// *** hdl/coherence_error_capture.sv ***
// Error capture and reporting block with an AXI4-Lite register port.
//
// Operation
// - Capture cause and address on error.
// - Load 6-bit kind into cause bits 63:58.
// - Load 58-bit detail together with kind.
// - New error replaces a correctable ECC record.
// - Otherwise log only second kind separately.
// - Reset or write-back of kind clears both.
// - Interrupt only when mask bit kind is set.
// - Error response returned when source needs it, mask independent.
// - Kinds 1,3,4 are L2 ECC/parity errors.
// - Kind 2 decode error answers requester.
// - Kind 5 records failed fetch-and-lock.
// - Kinds 6,7,8 are bus unit errors.
// - Kinds 10-13,15 defined; 0,9,14 reserved.
// - Detail bit 57: tag 0, data 1.
// - Way one-hot 44:29, bank bit 28.
// - Requester 27:22, cores then I/O units.
// - Hart 21:18, command 17:14, group 13:11.
// - Attribute 10:8, size 7:5, type 4:1.
// - Bit 0 scheduler, zero with one scheduler.
// - Command group codes 0-2 and 4-7; 3 undefined.
//
// The AXI4-Lite register port was decided locally.
module coherence_error_capture #(
  parameter int NUM_CORES = 4,       // Cores ahead of I/O units.
  parameter int NUM_SCHEDULERS = 1   // Pipeline schedulers built.
) (
  input wire logic aclk,                             // Clock.
  input wire logic aresetn,                          // Sync reset.
  input wire err_capture_pkg::error_event_s err_in,  // Error event.
  input wire logic err_needs_resp,                   // Source expects answer.
  output logic err_resp_ff,                          // Error response pulse.
  output logic irq_ff,                               // Interrupt pulse.
  input wire logic [7:0] s_axi_awaddr,               // Write address.
  input wire logic s_axi_awvalid,                    // Write address valid.
  output logic s_axi_awready,                        // Write address ready.
  input wire logic [31:0] s_axi_wdata,               // Write data.
  input wire logic [3:0] s_axi_wstrb,                // Byte strobes.
  input wire logic s_axi_wvalid,                     // Write data valid.
  output logic s_axi_wready,                         // Write data ready.
  output logic [1:0] s_axi_bresp,                    // Write response.
  output logic s_axi_bvalid,                         // Write response valid.
  input wire logic s_axi_bready,                     // Write response ready.
  input wire logic [7:0] s_axi_araddr,               // Read address.
  input wire logic s_axi_arvalid,                    // Read address valid.
  output logic s_axi_arready,                        // Read address ready.
  output logic [31:0] s_axi_rdata,                   // Read data.
  output logic [1:0] s_axi_rresp,                    // Read response.
  output logic s_axi_rvalid,                         // Read data valid.
  input wire logic s_axi_rready                      // Read data ready.
);

  // ************************************************************
  // Storage
  // ************************************************************
  // Register map, one aligned 32-bit word per offset:
  //   mask low and high words, read and write, byte strobes honoured;
  //   cause low word, detail bits 31:0, read only;
  //   cause high word, kind in 31:26 and detail 57:32, written only to
  //   clear the held kind;
  //   address low and high words, read only;
  //   multiple-error kind in bits 5:0, read only;
  //   scheduler count flag in bit 0, read only.
  // Any other offset answers with a slave error and reads as zero.
  // Software-visible state.
  logic [63:0] mask_ff;
  logic [5:0] kind_ff;
  logic [57:0] detail_ff;
  logic [63:0] addr_ff;
  logic [5:0] mult_kind_ff;
  // Write channel beats parked until both halves are in.
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_held_ff;
  logic w_held_ff;
  // Decode results and next values.
  logic clear_hit;
  logic do_write;
  logic load_cause;
  logic log_second;
  logic known_kind;
  logic [57:0] nxt_detail;
  logic [5:0] requester_code;
  logic [31:0] nxt_rdata;
  logic rd_hit;

  // ************************************************************
  // Error classification and detail assembly
  // ************************************************************

  // Only documented kinds are recorded; reserved codes are dropped.
  // Reserved codes still get their error answer, see below.
  // L2 kinds decoded.
  always_comb begin
    case (err_in.kind)
      // L2 cache and request decode kinds.
      err_capture_pkg::KIND_L2_CORR_ECC,
      err_capture_pkg::KIND_REQ_DECODE,
      err_capture_pkg::KIND_L2_UNCORR_ECC,
      err_capture_pkg::KIND_L2_PARITY,
      // Failed fetch-and-lock.
      err_capture_pkg::KIND_LOCK_FETCH,
      // Bus interface unit kinds.
      err_capture_pkg::KIND_BUS_DECODE,
      err_capture_pkg::KIND_BUS_PARITY,
      err_capture_pkg::KIND_BUS_RESP,
      // Ring bus, I/O unit and network register kinds.
      err_capture_pkg::KIND_RING_BUS,
      err_capture_pkg::KIND_IO_REQUEST,
      err_capture_pkg::KIND_IO_PARITY,
      err_capture_pkg::KIND_IO_RESP,
      err_capture_pkg::KIND_NET_REG_REQ: known_kind = 1'b1;
      default: known_kind = 1'b0;
    endcase
  end

  // The source numbers its requester itself: cores take codes from zero
  // up to NUM_CORES - 1 and I/O units follow directly. The code passes
  // unchanged so software sees exactly what the source reported.
  // Requester code pass.
  assign requester_code = err_in.info.requester;

  // Detail layout; reserved bits 56:45 read as zero.
  // Tag or data.
  always_comb begin
    nxt_detail = '0;
    // Tag or data flag; bits 56:45 stay zero.
    nxt_detail[57] = err_in.info.data_not_tag;
    // Location: one-hot way and bank.
    nxt_detail[44:29] = err_in.info.way_hot;
    nxt_detail[28] = err_in.info.bank;
    // Who asked: requester and hart.
    nxt_detail[27:22] = requester_code;
    nxt_detail[21:18] = err_in.info.hart;
    // What was asked: command, group, attribute, size and type.
    nxt_detail[17:14] = err_in.info.command;
    nxt_detail[13:11] = err_in.info.cmd_group;
    nxt_detail[10:8] = err_in.info.coherency_attribute;
    nxt_detail[7:5] = err_in.info.size_exp;
    nxt_detail[4:1] = err_in.info.txn_type;
    // With one scheduler the bit is tied low, so software need not mask it.
    nxt_detail[0] = (NUM_SCHEDULERS > 1) ? err_in.info.scheduler : 1'b0;
  end

  // ************************************************************
  // Register write path
  // ************************************************************

  // Address and data are latched independently, in either order.
  // A beat stays parked here until both halves are in and it is done.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // Both halves present and no response pending. Waiting for the
  // previous answer to be taken keeps a single write in flight, while
  // the next beats may already be parked.
  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

  // Each ready drops in the cycle after its handshake, so a parked beat
  // is never overwritten by a second one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Unmapped or read-only targets answer SLVERR.
  // Such a write changes nothing, so a stray store cannot disturb the
  // captured record.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= err_capture_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (awaddr_ff)
        err_capture_pkg::MASK_LO_OFF,
        err_capture_pkg::MASK_HI_OFF,
        err_capture_pkg::CAUSE_HI_OFF:
          s_axi_bresp <= err_capture_pkg::RESP_OKAY;
        default: s_axi_bresp <= err_capture_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Mask register, byte-lane writable.
  // A write with no strobe set completes with OKAY and changes nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= err_capture_pkg::MASK_RESET;
    end else if (do_write) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb_ff[i] && awaddr_ff == err_capture_pkg::MASK_LO_OFF) begin
          mask_ff[8*i +: 8] <= wdata_ff[8*i +: 8];
        end
        if (wstrb_ff[i] && awaddr_ff == err_capture_pkg::MASK_HI_OFF) begin
          mask_ff[32 + 8*i +: 8] <= wdata_ff[8*i +: 8];
        end
      end
    end
  end

  // Only a nonzero held kind can be cleared; writing zero over an empty
  // record is harmless and leaves both kind fields at zero.
  // The kind field sits in the top byte of the upper word, so byte
  // lane 3 must be enabled for a clear to count.
  // Write-back clear.
  assign clear_hit = do_write && awaddr_ff == err_capture_pkg::CAUSE_HI_OFF
    && wstrb_ff[3] && kind_ff != err_capture_pkg::KIND_NONE
    && wdata_ff[31:err_capture_pkg::KIND_LSB_HI] == kind_ff;

  // ************************************************************
  // Capture logic
  // ************************************************************

  // A correctable record is replaceable; anything else is sticky.
  // A clear in the same cycle frees the record for the new error.
  // Replace correctable.
  assign load_cause = err_in.valid && known_kind &&
    (kind_ff == err_capture_pkg::KIND_NONE ||
     kind_ff == err_capture_pkg::KIND_L2_CORR_ECC || clear_hit);

  // Reserved kinds fall out here as well and leave no trace.
  // Second kind only.
  assign log_second = err_in.valid && known_kind && !load_cause;

  // Address and detail load only together with the kind, so a logged
  // second error never disturbs the first record.
  // A new error in the clearing cycle wins over the clear.
  // Capture record.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_ff <= err_capture_pkg::KIND_NONE;
      detail_ff <= '0;
      addr_ff <= 64'h0000_0000_0000_0000;
    end else if (load_cause) begin
      kind_ff <= err_in.kind;
      detail_ff <= nxt_detail;
      addr_ff <= err_in.address;
    end else if (clear_hit) begin
      kind_ff <= err_capture_pkg::KIND_NONE;
    end
  end

  // Multiple-error kind keeps the latest second error.
  // Only the kind is kept; a later second error overwrites an earlier
  // one, so software sees the most recent.
  // Clear second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mult_kind_ff <= err_capture_pkg::KIND_NONE;
    end else if (log_second) begin
      mult_kind_ff <= err_in.kind;
    end else if (clear_hit) begin
      mult_kind_ff <= err_capture_pkg::KIND_NONE;
    end
  end

  // ************************************************************
  // Interrupt and error answer
  // ************************************************************

  // Interrupt follows a cause load; error answer ignores the mask.
  // Reserved kinds never load the cause and so never interrupt, but
  // their source still receives its error answer.
  // Masked interrupt.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
      err_resp_ff <= 1'b0;
    end else begin
      irq_ff <= load_cause && mask_ff[err_in.kind];
      err_resp_ff <= err_in.valid && err_needs_resp;
    end
  end

  // ************************************************************
  // Register read path
  // ************************************************************

  // Read data is chosen from the address as offered and registered at
  // the handshake, so rdata stands unchanged while rvalid waits.
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      err_capture_pkg::MASK_LO_OFF: nxt_rdata = mask_ff[31:0];
      err_capture_pkg::MASK_HI_OFF: nxt_rdata = mask_ff[63:32];
      // Cause is split: detail low word, then kind above upper detail.
      err_capture_pkg::CAUSE_LO_OFF: nxt_rdata = detail_ff[31:0];
      err_capture_pkg::CAUSE_HI_OFF: nxt_rdata = {kind_ff, detail_ff[57:32]};
      err_capture_pkg::ADDR_LO_OFF: nxt_rdata = addr_ff[31:0];
      err_capture_pkg::ADDR_HI_OFF: nxt_rdata = addr_ff[63:32];
      err_capture_pkg::MULT_OFF: nxt_rdata = {26'h0, mult_kind_ff};
      err_capture_pkg::SCHED_CFG_OFF:
        nxt_rdata = {31'h0, NUM_SCHEDULERS > 1};
      default: begin
        nxt_rdata = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read address is taken only while no read data is outstanding.
  // Trade-off: arready returns one cycle after the data is taken, which
  // costs a cycle per read but keeps rready off any path to arready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= err_capture_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= rd_hit ? err_capture_pkg::RESP_OKAY :
                              err_capture_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : coherence_error_capture

// *** hdl/err_capture_pkg.sv ***
// Package with register map, field layout and error kind codes.
package err_capture_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] MASK_LO_OFF = 8'h40;
  localparam logic [7:0] MASK_HI_OFF = 8'h44;
  localparam logic [7:0] CAUSE_LO_OFF = 8'h50;
  localparam logic [7:0] CAUSE_HI_OFF = 8'h54;
  localparam logic [7:0] ADDR_LO_OFF = 8'h58;
  localparam logic [7:0] ADDR_HI_OFF = 8'h5C;
  localparam logic [7:0] MULT_OFF = 8'h60;
  localparam logic [7:0] SCHED_CFG_OFF = 8'h64;

  // ************************************************************
  // Field positions and widths
  // ************************************************************
  localparam int KIND_W = 6;
  localparam int DETAIL_W = 58;
  localparam int KIND_LSB_HI = 26;
  localparam int WAY_W = 16;
  localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0000;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Error kind codes
  // ************************************************************
  localparam logic [5:0] KIND_NONE = 6'h00;
  localparam logic [5:0] KIND_L2_CORR_ECC = 6'h01;
  localparam logic [5:0] KIND_REQ_DECODE = 6'h02;
  localparam logic [5:0] KIND_L2_UNCORR_ECC = 6'h03;
  localparam logic [5:0] KIND_L2_PARITY = 6'h04;
  localparam logic [5:0] KIND_LOCK_FETCH = 6'h05;
  localparam logic [5:0] KIND_BUS_DECODE = 6'h06;
  localparam logic [5:0] KIND_BUS_PARITY = 6'h07;
  localparam logic [5:0] KIND_BUS_RESP = 6'h08;
  localparam logic [5:0] KIND_RING_BUS = 6'h0A;
  localparam logic [5:0] KIND_IO_REQUEST = 6'h0B;
  localparam logic [5:0] KIND_IO_PARITY = 6'h0C;
  localparam logic [5:0] KIND_IO_RESP = 6'h0D;
  localparam logic [5:0] KIND_NET_REG_REQ = 6'h0F;

  // Command group codes.
  localparam logic [2:0] GRP_NORMAL = 3'h0;
  localparam logic [2:0] GRP_REGS = 3'h1;
  localparam logic [2:0] GRP_GLOBAL = 3'h2;
  localparam logic [2:0] GRP_L1I = 3'h4;
  localparam logic [2:0] GRP_L1D = 3'h5;
  localparam logic [2:0] GRP_L3 = 3'h6;
  localparam logic [2:0] GRP_L2 = 3'h7;

  // Transfer size exponent codes that never occur.
  localparam logic [2:0] SIZE_UNUSED_A = 3'h5;
  localparam logic [2:0] SIZE_UNUSED_B = 3'h7;

  // Source-side description of one detected error.
  typedef struct packed {
    logic data_not_tag;   // Bit 57 of the detail.
    logic [15:0] way_hot; // One-hot way, bit 0 is way 0.
    logic bank;
    logic [5:0] requester;
    logic [3:0] hart;
    logic [3:0] command;
    logic [2:0] cmd_group;
    logic [2:0] coherency_attribute;
    logic [2:0] size_exp;
    logic [3:0] txn_type;
    logic scheduler;
  } error_detail_s;

  // Error event presented by a source.
  typedef struct packed {
    logic valid;
    logic [5:0] kind;
    logic [63:0] address;
    error_detail_s info;
  } error_event_s;

endpackage : err_capture_pkg

// *** verif/err_capture_chk_asserts.sv ***
// Concurrent checks on the ports of the error capture block.
module err_capture_chk (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Sync reset, active low.
  input wire err_capture_pkg::error_event_s err_in, // Error event.
  input wire logic err_needs_resp, // Source expects answer.
  input wire logic err_resp_ff, // Error response.
  input wire logic irq_ff, // Interrupt.
  input wire logic s_axi_awvalid, // AW valid.
  input wire logic s_axi_awready, // AW ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic [1:0] s_axi_bresp, // B response.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic s_axi_bready, // B ready.
  input wire logic s_axi_arvalid, // AR valid.
  input wire logic s_axi_arready, // AR ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready // R ready.
);
  // ********
  // Properties
  // ********
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // The answer does not depend on the mask, only on the source's need.
  chk_resp_follows: assert property
    (err_in.valid && err_needs_resp |=> err_resp_ff)
    else $error("error response missing");
  chk_resp_cause: assert property
    (err_resp_ff |-> $past(err_in.valid) && $past(err_needs_resp))
    else $error("error response without request");
  chk_irq_cause: assert property
    (irq_ff |-> $past(err_in.valid))
    else $error("interrupt without error event");
  // Reserved kinds never load the cause, so they never interrupt.
  chk_irq_reserved: assert property
    (irq_ff |-> !($past(err_in.kind) inside {6'h00, 6'h09, 6'h0E}))
    else $error("interrupt on reserved kind");
  // Bus answers stand until taken.
  chk_b_stands: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_stands: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_latency: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_latency: assert property
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
     |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  chk_aw_refused: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
endmodule : err_capture_chk

bind coherence_error_capture err_capture_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .err_in(err_in),
  .err_needs_resp(err_needs_resp), .err_resp_ff(err_resp_ff),
  .irq_ff(irq_ff), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// *** verif/tb_top.sv ***
// Directed register-bus and error-event bench for the capture block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Signals
  // ********
  localparam logic [1:0] OK = err_capture_pkg::RESP_OKAY;
  localparam logic [1:0] SE = err_capture_pkg::RESP_SLVERR;
  localparam logic [7:0] CHI = err_capture_pkg::CAUSE_HI_OFF;
  localparam logic [7:0] CLO = err_capture_pkg::CAUSE_LO_OFF;
  localparam logic [7:0] ALO = err_capture_pkg::ADDR_LO_OFF;
  localparam logic [7:0] MLT = err_capture_pkg::MULT_OFF;
  localparam logic [7:0] MLO = err_capture_pkg::MASK_LO_OFF;
  localparam logic [7:0] MHI = err_capture_pkg::MASK_HI_OFF;
  localparam logic [7:0] OFFS [7] = '{MLO, MHI, CLO, CHI, ALO,
    err_capture_pkg::ADDR_HI_OFF, MLT};
  localparam logic [5:0] KINDS [13] = '{6'h01, 6'h02, 6'h03, 6'h04,
    6'h05, 6'h06, 6'h07, 6'h08, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0F};
  logic aclk, aresetn, err_needs_resp, err_resp_ff, irq_ff;
  err_capture_pkg::error_event_s err_in;
  err_capture_pkg::error_detail_s inf_a, inf_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [63:0] mask_m;
  logic [57:0] dt;
  int mismatches, compares;

  coherence_error_capture #(.NUM_CORES(4), .NUM_SCHEDULERS(1)) uut (
    .aclk, .aresetn, .err_in, .err_needs_resp, .err_resp_ff, .irq_ff,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // ********
  // Tasks
  // ********
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Detail as it should read back: reserved bits zero, and with one
  // scheduler built the scheduler bit is zero whatever the source says.
  function automatic logic [57:0] det(input err_capture_pkg::error_detail_s i);
    return {i.data_not_tag, 12'h000, i[44:1], 1'b0};
  endfunction : det

  // Address and data are offered together; bready is held high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er}, "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    check({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er}, "rresp");
    check(s_axi_rdata, ed, $sformatf("rdata %h", a));
  endtask : rd

  // One-cycle error event; the pulses are looked at one cycle later.
  task automatic fire(input logic [5:0] k, input logic nr,
                      input err_capture_pkg::error_detail_s inf,
                      input logic [63:0] ad, input logic ck_irq);
    err_in <= {1'b1, k, ad, inf};
    err_needs_resp <= nr;
    @(posedge aclk);
    err_in <= '0;
    err_needs_resp <= 1'b0;
    @(posedge aclk);
    check({30'h0, err_resp_ff, ck_irq & irq_ff},
          {30'h0, nr, ck_irq & mask_m[k]}, "event pulses");
  endtask : fire

  // ********
  // Clock, watchdog and tests
  // ********
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // The tests take some 200 cycles; a hang is cut far beyond that.
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end

  initial begin
    {aresetn, err_needs_resp, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    err_in = '0;
    {mismatches, compares} = '0;
    inf_a = 46'h29C3_A5B7_ED1F;
    inf_b = ~inf_a;
    mask_m = 64'h0000_0000_00FF_00A8;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (OFFS[i]) rd(OFFS[i], 32'h0, OK);
    rd(err_capture_pkg::SCHED_CFG_OFF, 32'h0, OK);
    wr(MLO, 32'h0000_00A8, 4'hF, OK);
    wr(MLO, 32'hFFFF_FFFF, 4'h4, OK);
    rd(MLO, 32'h00FF_00A8, OK);
    wr(MHI, 32'h8000_0001, 4'hF, OK);
    rd(MHI, 32'h8000_0001, OK);
    fire(6'h01, 1'b1, inf_a, 64'h1234_5678_9ABC_DEF0, 1'b1);
    dt = det(inf_a);
    rd(CHI, {6'h01, dt[57:32]}, OK);
    rd(CLO, dt[31:0], OK);
    rd(ALO, 32'h9ABC_DEF0, OK);
    fire(6'h03, 1'b0, inf_b, 64'h0FED_CBA9_8765_4321, 1'b1);
    dt = det(inf_b);
    rd(CHI, {6'h03, dt[57:32]}, OK);
    rd(CLO, dt[31:0], OK);
    rd(ALO, 32'h8765_4321, OK);
    fire(6'h07, 1'b1, inf_a, 64'h0, 1'b0);
    fire(6'h09, 1'b1, inf_a, 64'h0, 1'b1);
    rd(MLT, 32'h7, OK);
    rd(CHI, {6'h03, dt[57:32]}, OK);
    rd(ALO, 32'h8765_4321, OK);
    fire(6'h02, 1'b1, inf_a, 64'h0, 1'b0);
    rd(MLT, 32'h2, OK);
    wr(CHI, {6'h04, 26'h0}, 4'hF, OK);
    rd(CHI, {6'h03, dt[57:32]}, OK);
    rd(MLT, 32'h2, OK);
    wr(CHI, {6'h03, 26'h0}, 4'h8, OK);
    rd(CHI, {6'h00, dt[57:32]}, OK);
    rd(MLT, 32'h0, OK);
    dt = det(inf_a);
    foreach (KINDS[i]) begin
      fire(KINDS[i], 1'b0, inf_a, 64'h0, 1'b1);
      rd(CHI, {KINDS[i], dt[57:32]}, OK);
      wr(CHI, {KINDS[i], 26'h0}, 4'h8, OK);
    end
    rd(8'h80, 32'h0, SE);
    wr(ALO, 32'hFFFF_FFFF, 4'hF, SE);
    fire(6'h0D, 1'b1, inf_b, 64'h0000_0000_0000_00C3, 1'b1);
    fire(6'h04, 1'b0, inf_a, 64'h0, 1'b0);
    rd(MLT, 32'h4, OK);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(CHI, 32'h0, OK);
    rd(CLO, 32'h0, OK);
    rd(ALO, 32'h0, OK);
    rd(MLT, 32'h0, OK);
    rd(MHI, 32'h0, OK);
    stop_test();
  end
endmodule : tb_top
